/* File: design/lcr_pkg.sv */
// package: register map, field layout and types for the channel config bank
package lcr_pkg;
  // channel count and address layout (word index, byte address = 4 * index)
  localparam int          NUM_CHAN     = 8;
  localparam logic [7:0]  CHAN_STRIDE  = 8'h10;
  localparam logic [3:0]  REG_EQ_IDX   = 4'h0;
  localparam logic [3:0]  REG_TJ_IDX   = 4'h1;
  localparam logic [3:0]  REG_TP_IDX   = 4'h2;
  localparam logic [3:0]  REG_LC_IDX   = 4'h3;
  // reset values
  localparam logic [4:0]  EQ_RST       = 5'h00;
  localparam logic [7:0]  TJ_RST       = 8'h00;
  localparam logic [7:0]  TP_RST       = 8'h00;
  localparam logic        LC_RST       = 1'b0;
  // termination / jitter register fields
  localparam int          RX_TERM_BIT  = 7;
  localparam int          TX_TERM_BIT  = 6;
  localparam int          IMP_LSB      = 4;
  localparam int          JA_LSB       = 2;
  localparam int          JA_BW_BIT    = 1;
  localparam int          FIFO_BIT     = 0;
  // pattern / loopback register fields
  localparam int          INV_BIT      = 7;
  localparam int          TEST_LSB     = 4;
  localparam int          TXPWR_BIT    = 3;
  localparam int          LOOP_LSB     = 0;
  // coding register field
  localparam int          CODING_BIT   = 5;
  // equalizer code ranges
  localparam logic [4:0]  EQ_T1_SH_LO  = 5'h08;
  localparam logic [4:0]  EQ_T1_SH_ARB = 5'h0d;
  localparam logic [4:0]  EQ_T1_GN_LO  = 5'h0e;
  localparam logic [4:0]  EQ_T1_GN_ARB = 5'h13;
  localparam logic [4:0]  EQ_E1_LO     = 5'h1c;
  localparam logic [4:0]  EQ_E1_GN_LO  = 5'h1e;
  // attenuator fifo depths in bits
  localparam logic [6:0]  FIFO_SHALLOW = 7'h20;
  localparam logic [6:0]  FIFO_DEEP    = 7'h40;

  typedef enum logic [1:0] {PAT_NONE, PAT_QRSS, PAT_ALL_ONES, PAT_RSVD} lcr_pat_t;
  typedef enum logic [2:0] {LB_NONE, LB_DUAL, LB_ANALOG, LB_REMOTE, LB_DIGITAL} lcr_loop_t;
  typedef enum logic [1:0] {CODE_B8ZS, CODE_HDB3, CODE_AMI} lcr_code_t;
  typedef enum logic [1:0] {BW_10HZ, BW_1P5HZ, BW_3HZ} lcr_bw_t;

  // decoded line configuration of one channel
  typedef struct packed {
    logic       eq_valid;      // code is a defined mode
    logic       eq_e1;         // e1 mode, else t1
    logic       eq_gain;       // 29 dB gain mode, else 15 dB
    logic       eq_arb_pulse;  // arbitrary pulse shape
    logic [2:0] eq_lbo;        // build-out step 0..5
    logic       eq_coax75;     // 75 ohm coax, else twisted pair
    logic       rx_term_en;    // receive internal termination
    logic       tx_term_en;    // transmit internal termination
    logic [1:0] line_impedance;
    logic       ja_tx;         // attenuator in transmit path
    logic       ja_rx;         // attenuator in receive path
    lcr_bw_t    ja_bw;
    logic [6:0] fifo_depth;
    logic [6:0] fifo_delay;
    lcr_pat_t   pattern;
    logic       pattern_invert;
    logic       tx_power;
    lcr_loop_t  loopback;
    lcr_code_t  line_code;
  } lcr_cfg_t;
endpackage : lcr_pkg

/* File: design/lcr_top.sv */
// top: per-channel line configuration registers behind an avalon-mm slave
module lcr_top (
  input  wire logic                            I_REF_CLK,          // 10 mhz clock
  input  wire logic                            I_RESET,            // sync reset, high
  input  wire logic [9:0]                      I_AVS_ADDRESS,      // byte address
  input  wire logic                            I_AVS_READ,         // read request
  input  wire logic                            I_AVS_WRITE,        // write request
  input  wire logic [31:0]                     I_AVS_WRITEDATA,    // write data
  input  wire logic [3:0]                      I_AVS_BYTEENABLE,   // byte lanes
  output logic      [31:0]                     O_AVS_READDATA,     // read data
  output logic                                 O_AVS_WAITREQUEST,  // stall
  input  wire logic                            I_GLOBAL_TX_EN_PIN, // async pin
  input  wire logic                            I_SINGLE_RAIL,      // single-rail mode
  output lcr_pkg::lcr_cfg_t [lcr_pkg::NUM_CHAN-1:0] O_CHAN_CFG     // decoded config
);

  localparam int NC = lcr_pkg::NUM_CHAN;

  // stored fields per channel
  logic [4:0]                eq_ff [NC];       // equalizer code
  logic [4:0]                nxt_eq [NC];
  logic [7:0]                tj_ff [NC];       // termination / jitter
  logic [7:0]                nxt_tj [NC];
  logic [7:0]                tp_ff [NC];       // pattern / loopback
  logic [7:0]                nxt_tp [NC];
  logic                      lc_ff [NC];       // coding select
  logic                      nxt_lc [NC];
  // bus handshake
  logic                      wait_ff;          // waitrequest
  logic                      nxt_wait;
  logic [31:0]               rdata_ff;         // read data
  logic [31:0]               nxt_rdata;
  // pin synchroniser
  logic                      txen_meta_ff;     // first stage
  logic                      txen_ff;          // second stage
  // registered outputs
  lcr_pkg::lcr_cfg_t [NC-1:0] cfg_ff;
  lcr_pkg::lcr_cfg_t [NC-1:0] nxt_cfg;
  // address decode
  logic [7:0]                idx;              // word index
  logic [2:0]                chan;             // channel number
  logic [3:0]                sub;              // register within channel
  logic                      in_chan;          // channel region hit

  // word index; channel n sits at n * stride
  // channel address split
  assign idx     = I_AVS_ADDRESS[9:2];
  assign chan    = idx[6:4];
  assign sub     = idx[3:0];
  assign in_chan = (idx < (lcr_pkg::CHAN_STRIDE * 8'(NC)));

  // two-flop synchroniser for the global enable pin
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RESET)
    begin
      txen_meta_ff <= 1'b0;
      txen_ff      <= 1'b0;
    end
    else
    begin
      txen_meta_ff <= I_GLOBAL_TX_EN_PIN;
      txen_ff      <= txen_meta_ff;
    end
  end

  // bus handshake: one wait cycle, commit when waitrequest is low
  always_comb
  begin
    nxt_wait  = 1'b1;
    nxt_rdata = rdata_ff;
    if ((I_AVS_READ || I_AVS_WRITE) && wait_ff)
    begin
      // drop waitrequest next cycle
      nxt_wait = 1'b0;
    end
    if (I_AVS_READ && wait_ff)
    begin
      nxt_rdata = 32'h0000_0000;
      if (in_chan)
      begin
        if (sub == lcr_pkg::REG_EQ_IDX)
        begin
          nxt_rdata[4:0] = eq_ff[chan];
        end
        else if (sub == lcr_pkg::REG_TJ_IDX)
        begin
          nxt_rdata[7:0] = tj_ff[chan];
        end
        else if (sub == lcr_pkg::REG_TP_IDX)
        begin
          nxt_rdata[7:0] = tp_ff[chan];
        end
        else if (sub == lcr_pkg::REG_LC_IDX)
        begin
          nxt_rdata[lcr_pkg::CODING_BIT] = lc_ff[chan];
        end
        else
        begin
          // unmapped in channel: zero
          nxt_rdata = 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RESET)
    begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // register writes, low byte lane only
  always_comb
  begin
    for (int c = 0; c < NC; c++)
    begin
      nxt_eq[c] = eq_ff[c];
      nxt_tj[c] = tj_ff[c];
      nxt_tp[c] = tp_ff[c];
      nxt_lc[c] = lc_ff[c];
    end
    if (I_AVS_WRITE && !wait_ff && I_AVS_BYTEENABLE[0] && in_chan)
    begin
      if (sub == lcr_pkg::REG_EQ_IDX)
      begin
        nxt_eq[chan] = I_AVS_WRITEDATA[4:0];
      end
      else if (sub == lcr_pkg::REG_TJ_IDX)
      begin
        nxt_tj[chan] = I_AVS_WRITEDATA[7:0];
      end
      else if (sub == lcr_pkg::REG_TP_IDX)
      begin
        nxt_tp[chan] = I_AVS_WRITEDATA[7:0];
      end
      else if (sub == lcr_pkg::REG_LC_IDX)
      begin
        nxt_lc[chan] = I_AVS_WRITEDATA[lcr_pkg::CODING_BIT];
      end
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    for (int c = 0; c < NC; c++)
    begin
      if (I_RESET)
      begin
        eq_ff[c] <= lcr_pkg::EQ_RST;
        tj_ff[c] <= lcr_pkg::TJ_RST;
        tp_ff[c] <= lcr_pkg::TP_RST;
        lc_ff[c] <= lcr_pkg::LC_RST;
      end
      else
      begin
        eq_ff[c] <= nxt_eq[c];
        tj_ff[c] <= nxt_tj[c];
        tp_ff[c] <= nxt_tp[c];
        lc_ff[c] <= nxt_lc[c];
      end
    end
  end

  // decode of stored fields into line configuration
  always_comb
  begin
    for (int c = 0; c < NC; c++)
    begin
      nxt_cfg[c] = '0;
      if (eq_ff[c] >= lcr_pkg::EQ_T1_SH_LO && eq_ff[c] <= lcr_pkg::EQ_T1_SH_ARB)
      begin
        nxt_cfg[c].eq_valid     = 1'b1;
        nxt_cfg[c].eq_arb_pulse = (eq_ff[c] == lcr_pkg::EQ_T1_SH_ARB);
        nxt_cfg[c].eq_lbo       = 3'(eq_ff[c] - lcr_pkg::EQ_T1_SH_LO);
      end
      else if (eq_ff[c] >= lcr_pkg::EQ_T1_GN_LO && eq_ff[c] <= lcr_pkg::EQ_T1_GN_ARB)
      begin
        nxt_cfg[c].eq_valid     = 1'b1;
        nxt_cfg[c].eq_gain      = 1'b1;
        nxt_cfg[c].eq_arb_pulse = (eq_ff[c] == lcr_pkg::EQ_T1_GN_ARB);
        nxt_cfg[c].eq_lbo       = 3'(eq_ff[c] - lcr_pkg::EQ_T1_GN_LO);
      end
      else if (eq_ff[c] >= lcr_pkg::EQ_E1_LO)
      begin
        nxt_cfg[c].eq_valid  = 1'b1;
        nxt_cfg[c].eq_e1     = 1'b1;
        nxt_cfg[c].eq_gain   = (eq_ff[c] >= lcr_pkg::EQ_E1_GN_LO);
        nxt_cfg[c].eq_coax75 = ~eq_ff[c][0];
      end
      nxt_cfg[c].rx_term_en = tj_ff[c][lcr_pkg::RX_TERM_BIT];
      nxt_cfg[c].tx_term_en = tj_ff[c][lcr_pkg::TX_TERM_BIT];
      nxt_cfg[c].line_impedance = tj_ff[c][lcr_pkg::IMP_LSB +: 2];
      nxt_cfg[c].ja_tx = (tj_ff[c][lcr_pkg::JA_LSB +: 2] == 2'h1);
      nxt_cfg[c].ja_rx = tj_ff[c][lcr_pkg::JA_LSB + 1];
      if (!nxt_cfg[c].eq_e1)
      begin
        nxt_cfg[c].ja_bw = lcr_pkg::BW_3HZ;
      end
      else if (tj_ff[c][lcr_pkg::JA_BW_BIT])
      begin
        nxt_cfg[c].ja_bw = lcr_pkg::BW_1P5HZ;
      end
      else
      begin
        nxt_cfg[c].ja_bw = lcr_pkg::BW_10HZ;
      end
      nxt_cfg[c].fifo_depth = tj_ff[c][lcr_pkg::FIFO_BIT] ?
                              lcr_pkg::FIFO_DEEP : lcr_pkg::FIFO_SHALLOW;
      nxt_cfg[c].fifo_delay = nxt_cfg[c].fifo_depth >> 1;
      case (tp_ff[c][lcr_pkg::TEST_LSB +: 3])
        3'h4:    nxt_cfg[c].pattern = lcr_pkg::PAT_QRSS;
        3'h5:    nxt_cfg[c].pattern = lcr_pkg::PAT_ALL_ONES;
        3'h6,
        3'h7:    nxt_cfg[c].pattern = lcr_pkg::PAT_RSVD;
        default: nxt_cfg[c].pattern = lcr_pkg::PAT_NONE;
      endcase
      nxt_cfg[c].pattern_invert = tp_ff[c][lcr_pkg::INV_BIT] &&
                                  (nxt_cfg[c].pattern == lcr_pkg::PAT_QRSS);
      nxt_cfg[c].tx_power = tp_ff[c][lcr_pkg::TXPWR_BIT] && txen_ff;
      case (tp_ff[c][lcr_pkg::LOOP_LSB +: 3])
        3'h4:    nxt_cfg[c].loopback = lcr_pkg::LB_DUAL;
        3'h5:    nxt_cfg[c].loopback = lcr_pkg::LB_ANALOG;
        3'h6:    nxt_cfg[c].loopback = lcr_pkg::LB_REMOTE;
        3'h7:    nxt_cfg[c].loopback = lcr_pkg::LB_DIGITAL;
        default: nxt_cfg[c].loopback = lcr_pkg::LB_NONE;
      endcase
      if (lc_ff[c] && I_SINGLE_RAIL)
      begin
        nxt_cfg[c].line_code = lcr_pkg::CODE_AMI;
      end
      else if (nxt_cfg[c].eq_e1)
      begin
        nxt_cfg[c].line_code = lcr_pkg::CODE_HDB3;
      end
      else
      begin
        nxt_cfg[c].line_code = lcr_pkg::CODE_B8ZS;
      end
    end
  end

  // registered decoded outputs
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RESET)
    begin
      cfg_ff <= '0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
    end
  end

  // outputs straight from flops
  assign O_AVS_READDATA    = rdata_ff;
  assign O_AVS_WAITREQUEST = wait_ff;
  assign O_CHAN_CFG        = cfg_ff;

endmodule : lcr_top

/* File: test/lcr_props.sv */
// checker: bus handshake and decoded config relations of the bank
module lcr_props (
  input wire logic                                 I_REF_CLK,          // clock
  input wire logic                                 I_RESET,            // sync reset
  input wire logic [9:0]                           I_AVS_ADDRESS,      // byte address
  input wire logic                                 I_AVS_READ,         // read strobe
  input wire logic                                 I_AVS_WRITE,        // write strobe
  input wire logic [31:0]                          I_AVS_WRITEDATA,    // write data
  input wire logic [3:0]                           I_AVS_BYTEENABLE,   // byte lanes
  input wire logic [31:0]                          O_AVS_READDATA,     // read data
  input wire logic                                 O_AVS_WAITREQUEST,  // stall
  input wire logic                                 I_GLOBAL_TX_EN_PIN, // tx enable pin
  input wire logic                                 I_SINGLE_RAIL,      // single rail
  input wire lcr_pkg::lcr_cfg_t [lcr_pkg::NUM_CHAN-1:0] O_CHAN_CFG    // decoded config
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  // any bus request
  wire logic req = I_AVS_READ | I_AVS_WRITE;
  // answered one cycle after being taken
  ack_one_cycle_a: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("request not answered after one wait");
  ack_pulse_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  ack_cause_a: assert property ($fell(O_AVS_WAITREQUEST) |-> $past(req))
    else $error("waitrequest dropped with no request");
  rdata_upper_a: assert property (!O_AVS_WAITREQUEST |-> O_AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  coding_rsvd_a: assert property (!O_AVS_WAITREQUEST && I_AVS_READ &&
    I_AVS_ADDRESS[5:2] == 4'h3 |-> (O_AVS_READDATA[7:0] & 8'hdf) == 8'h0)
    else $error("reserved coding bits read nonzero");
  unmapped_zero_a: assert property (!O_AVS_WAITREQUEST && I_AVS_READ &&
    (I_AVS_ADDRESS[9] || I_AVS_ADDRESS[5:2] > 4'h3) |-> O_AVS_READDATA == 32'h0)
    else $error("unmapped address read nonzero");
  tx_pin_gate_a: assert property (O_CHAN_CFG[0].tx_power |-> $past(I_GLOBAL_TX_EN_PIN, 3))
    else $error("transmitter on while pin low");
  rx_term_wr_a: assert property (!O_AVS_WAITREQUEST && I_AVS_WRITE && I_AVS_BYTEENABLE[0]
    && I_AVS_ADDRESS == 10'h004 |-> ##2 O_CHAN_CFG[0].rx_term_en == $past(I_AVS_WRITEDATA[7], 2))
    else $error("receive termination not following write");
  invert_qrss_a: assert property (O_CHAN_CFG[0].pattern_invert
    |-> O_CHAN_CFG[0].pattern == lcr_pkg::PAT_QRSS)
    else $error("inversion without qrss pattern");
  ja_exclusive_a: assert property (!(O_CHAN_CFG[0].ja_tx && O_CHAN_CFG[0].ja_rx))
    else $error("attenuator in both paths");
  ami_rail_a: assert property (O_CHAN_CFG[0].line_code == lcr_pkg::CODE_AMI
    |-> $past(I_SINGLE_RAIL))
    else $error("ami outside single rail mode");
endmodule : lcr_props

bind lcr_top lcr_props i_lcr_props (.I_REF_CLK, .I_RESET, .I_AVS_ADDRESS, .I_AVS_READ,
  .I_AVS_WRITE, .I_AVS_WRITEDATA, .I_AVS_BYTEENABLE, .O_AVS_READDATA, .O_AVS_WAITREQUEST,
  .I_GLOBAL_TX_EN_PIN, .I_SINGLE_RAIL, .O_CHAN_CFG);

/* File: test/tb_top.sv */
// testbench: register access and decoded config of the bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;       // reference clock
  logic        rst = 1'b1;       // sync reset
  logic [9:0]  adr = '0;         // byte address
  logic        rd = 1'b0;        // read strobe
  logic        wr = 1'b0;        // write strobe
  logic [31:0] wd = '0;          // write data
  logic [3:0]  be = 4'h0;        // byte lanes
  logic [31:0] rdat;             // read data
  logic        wreq;             // wait request
  logic        pin = 1'b1;       // global tx enable
  logic        sr = 1'b0;        // single rail
  lcr_pkg::lcr_cfg_t [lcr_pkg::NUM_CHAN-1:0] cfg; // decoded config
  int          error_cnt = 0;    // mismatches
  int          checks_done = 0;  // compares
  int          cyc = 0;          // timeout counter
  logic [31:0] got;              // last read value
  logic [7:0]  v;                // register value under test
  logic [4:0]  e5;               // equalizer code under test
  logic        vld;              // code is defined
  logic        e1;               // code is e1
  always #50 clk = ~clk;
  lcr_top i_lcr_top (.I_REF_CLK(clk), .I_RESET(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wreq), .I_GLOBAL_TX_EN_PIN(pin), .I_SINGLE_RAIL(sr), .O_CHAN_CFG(cfg));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one bus cycle, held until waitrequest sampled low
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  task automatic wrr(input logic [9:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'h1);
  endtask : wrr
  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 4'h0);
    chk(got, exp);
  endtask : rdc
  // let n edges pass, then sample settled outputs
  task automatic pwait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : pwait
  task automatic test_done();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // reset values on first and last channel
    for (int r = 0; r < 4; r++)
    begin
      rdc(10'(r * 4), 32'h0);
      rdc(10'(r * 4 + 'h1c0), 32'h0);
    end
    chk(cfg[0].fifo_depth, 32'h20);
    chk(cfg[0].ja_bw, lcr_pkg::BW_3HZ);
    $display("test reset done");
    // every equalizer code on channel 3
    for (int c = 0; c < 32; c++)
    begin
      wrr(10'h0c0, 32'(c) | 32'he0);
      pwait(1);
      e5 = 5'(c);
      vld = (e5 >= 5'h08 && e5 <= 5'h13) || e5 >= 5'h1c;
      e1 = e5 >= 5'h1c;
      rdc(10'h0c0, 32'(c));
      chk(cfg[3].eq_valid, vld);
      chk(cfg[3].eq_e1, e1);
      chk(cfg[3].eq_gain, vld && e5 >= 5'h0e && e5 != 5'h1c && e5 != 5'h1d);
      chk(cfg[3].eq_arb_pulse, e5 == 5'h0d || e5 == 5'h13);
      chk(cfg[3].eq_lbo, e5 inside {[8:13]} ? e5 - 8 : e5 inside {[14:19]} ? e5 - 14 : 0);
      chk(cfg[3].eq_coax75, e1 && !e5[0]);
      chk(cfg[3].line_code, e1 ? lcr_pkg::CODE_HDB3 : lcr_pkg::CODE_B8ZS);
    end
    $display("test equalizer done");
    // termination and jitter fields, e1 code on channel 0
    wrr(10'h000, 32'h1c);
    for (int j = 0; j < 16; j++)
    begin
      v = 8'(j * 17);
      wrr(10'h004, {24'h0, v});
      pwait(1);
      rdc(10'h004, {24'h0, v});
      chk(cfg[0].rx_term_en, v[7]);
      chk(cfg[0].tx_term_en, v[6]);
      chk(cfg[0].line_impedance, v[5:4]);
      chk(cfg[0].ja_tx, v[3:2] == 2'b01);
      chk(cfg[0].ja_rx, v[3]);
      chk(cfg[0].ja_bw, v[1] ? lcr_pkg::BW_1P5HZ : lcr_pkg::BW_10HZ);
      chk(cfg[0].fifo_depth, v[0] ? 32'h40 : 32'h20);
      chk(cfg[0].fifo_delay, v[0] ? 32'h20 : 32'h10);
    end
    wrr(10'h000, 32'h08);
    pwait(1);
    chk(cfg[0].ja_bw, lcr_pkg::BW_3HZ);
    // channel 7 copy holds its own value, channel 0 untouched
    wrr(10'h1c4, 32'h5a);
    pwait(1);
    rdc(10'h1c4, 32'h5a);
    rdc(10'h004, 32'hff);
    chk(cfg[7].line_impedance, 2'b01);
    chk(cfg[7].ja_rx, 1'b1);
    chk(cfg[0].line_impedance, 2'b11);
    $display("test termination done");
    // pattern, power and loopback fields
    for (int j = 0; j < 16; j++)
    begin
      v = 8'(j * 17);
      wrr(10'h008, {24'h0, v});
      pwait(1);
      rdc(10'h008, {24'h0, v});
      chk(cfg[0].pattern, !v[6] ? lcr_pkg::PAT_NONE : v[5] ? lcr_pkg::PAT_RSVD
        : v[4] ? lcr_pkg::PAT_ALL_ONES : lcr_pkg::PAT_QRSS);
      chk(cfg[0].pattern_invert, v[7] && v[6:4] == 3'b100);
      chk(cfg[0].tx_power, v[3]);
      chk(cfg[0].loopback, v[2] ? 3'd1 + v[1:0] : 3'd0);
    end
    @(posedge clk);
    pin <= 1'b0;
    pwait(4);
    chk(cfg[0].tx_power, 1'b0);
    // pin changes only on a rising edge
    @(posedge clk);
    pin <= 1'b1;
    pwait(4);
    chk(cfg[0].tx_power, 1'b1);
    $display("test pattern done");
    // coding select, single rail only
    wrr(10'h00c, 32'hff);
    rdc(10'h00c, 32'h20);
    pwait(1);
    chk(cfg[0].line_code, lcr_pkg::CODE_B8ZS);
    @(posedge clk);
    sr <= 1'b1;
    pwait(2);
    chk(cfg[0].line_code, lcr_pkg::CODE_AMI);
    $display("test coding done");
    // refused writes and unmapped places
    acc(1'b1, 10'h004, 32'h0, 4'he);
    rdc(10'h004, 32'hff);
    wrr(10'h200, 32'hff);
    rdc(10'h200, 32'h0);
    wrr(10'h010, 32'hff);
    rdc(10'h010, 32'h0);
    $display("test refusal done");
    // mid-run reset must clear channel 0 termination, coding and power fields
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(10'h004, 32'h0);
    rdc(10'h00c, 32'h0);
    pwait(1);
    chk(cfg[0].fifo_depth, 32'h20);
    chk(cfg[0].tx_power, 1'b0);
    chk(cfg[0].line_code, lcr_pkg::CODE_B8ZS);
    $display("test second reset done");
    test_done();
  end
endmodule : tb_top
